// file: src/apw_pkg.sv
// Package for the auto powerdown wake and pin-state block
// Function
// - Reset wake runs the full reset sequence
// - Register-access wake keeps all state intact
// - Motor enable write wakes; control read does not
// - Status read wakes; rate write does not
// - Any data port access wakes the part
// - Wake restarts the 10 ms countdown
// - Re-enter powerdown once conditions hold again
// - Offsets 0,1,2,4w,7 served without waking
// - Writes while down stored and effective later
// - Control/rate writes stay down unless motor/reset
// - Host bus live; interrupt and dma low
// - Tristate motor, select, write pins while down
// - Local logic pins keep working while down
// - Non-waking access returns to low power after
// - Auto powerdown only while enable bit set
// - Entry needs motors off, idle, head unloaded, timer
// - Status read or data access restarts countdown
package apw_pkg;
   localparam logic [2:0] OFS_DRIVE_CTRL  = 3'h2;
   localparam logic [2:0] OFS_RATE_STATUS = 3'h4;
   localparam logic [2:0] OFS_DATA_FIFO   = 3'h5;
   localparam logic [2:0] OFS_DISK_RATE   = 3'h7;
   localparam int         BIT_SW_RESET_DOR = 2;
   localparam int         BIT_SW_RESET_DSR = 7;
   localparam int         BIT_MOTOR_LO     = 4;
   localparam int         BIT_AUTO_PD      = 7;
   localparam logic [7:0] MAIN_STATUS_IDLE = 8'h80;
   localparam logic [7:0] DOR_RESET_VAL    = 8'h00;
   localparam logic [7:0] DSR_RESET_VAL    = 8'h02;
   localparam logic [7:0] CCR_RESET_VAL    = 8'h02;
   localparam int         CLK_MHZ          = 250;
   localparam int         PD_TIME_MS       = 10;
   localparam int         PD_CYCLES        = PD_TIME_MS * 1000 * CLK_MHZ;
   localparam int         CNT_W            = 22;

   typedef enum logic [2:0] {
      APW_RESET = 3'b001,
      APW_AWAKE = 3'b010,
      APW_DOWN  = 3'b100
   } apw_state_t;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [2:0] addr;
      logic [7:0] wdata;
   } apw_host_t;

   typedef struct packed {
      logic [3:0] motor_on;
      logic [3:0] drive_sel;
      logic       write_stream;
      logic       write_enable;
      logic       direction;
      logic       step;
      logic       head_sel;
      logic       density_sel;
      logic [1:0] rate_code;
   } apw_drive_t;
endpackage

// file: src/apw_wake.sv
// Auto powerdown wake decision, timer and pin-state control
`timescale 1ns/1ps
`default_nettype none
module apw_wake
   import apw_pkg::*;
#(
   parameter int PD_COUNT = PD_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       host_read_strobe,
   input  wire logic       host_write_strobe,
   input  wire logic [2:0] host_addr,
   input  wire logic [7:0] host_wdata,
   input  wire logic [7:0] main_status_in,
   input  wire logic       core_irq_in,
   input  wire logic       core_dma_req_in,
   input  wire logic       head_unload_done_in,
   input  wire logic [7:0] power_config_seven,
   input  wire apw_drive_t core_drive_in,
   output logic [7:0]      host_rdata,
   output logic            irq_out,
   output logic            dma_request_out,
   output logic            soft_reset_out,
   output logic            core_clock_enable,
   output logic            powered_down,
   output apw_drive_t      drive_out,
   output logic [3:0]      motor_on_oe_n,
   output logic [3:0]      drive_select_oe_n,
   output logic            write_stream_oe_n,
   output logic            write_enable_oe_n
);
   typedef struct packed {
      apw_state_t  fsm;
      logic [2:0]  rd_last;
      logic [2:0]  wr_last;
      apw_host_t   hs1;
      apw_host_t   hs2;
      logic [7:0]  drive_output_control;
      logic [7:0]  dsr;
      logic [7:0]  rate_config;
      logic [CNT_W-1:0] timer;
      logic [7:0]  rdata;
      logic        irq;
      logic        dma;
      logic        srst;
      logic        cken;
      logic        down;
      apw_drive_t  drv;
      logic        tri_n;
   } apw_regs_t;

   apw_regs_t s_reg;
   apw_regs_t s_next;

   logic rd_evt;
   logic wr_evt;
   logic wake_access;
   logic wake_reset;
   logic entry_ok;
   logic [7:0] wd;
   logic [2:0] ad;

   // Host strobes arrive from pins; the address and data settle before them
   assign rd_evt = s_reg.hs2.read & ~s_reg.rd_last[0];
   assign wr_evt = s_reg.hs2.write & ~s_reg.wr_last[0];
   assign wd     = s_reg.hs2.wdata;
   assign ad     = s_reg.hs2.addr;

   always_comb begin
      wake_reset = 1'b0;
      wake_access = 1'b0;
      if (wr_evt && ad == OFS_DRIVE_CTRL) begin
         if (wd[7:BIT_MOTOR_LO] != 4'h0) begin
            wake_access = 1'b1;
         end
         if (!wd[BIT_SW_RESET_DOR]) begin
            wake_reset = 1'b1;
         end
      end else if (wr_evt && ad == OFS_RATE_STATUS) begin
         wake_reset = wd[BIT_SW_RESET_DSR];
      end else if (rd_evt && ad == OFS_RATE_STATUS) begin
         wake_access = 1'b1;
      end else if ((rd_evt || wr_evt) && ad == OFS_DATA_FIFO) begin
         wake_access = 1'b1;
      end
   end

   assign entry_ok = s_reg.drive_output_control[7:BIT_MOTOR_LO] == 4'h0
                  && main_status_in == MAIN_STATUS_IDLE
                  && !core_irq_in
                  && head_unload_done_in
                  && s_reg.timer == '0;

   always_comb begin
      s_next = s_reg;
      s_next.hs1 = '{host_read_strobe, host_write_strobe, host_addr, host_wdata};
      s_next.hs2 = s_reg.hs1;
      s_next.rd_last = {2'b00, s_reg.hs2.read};
      s_next.wr_last = {2'b00, s_reg.hs2.write};
      s_next.srst = 1'b0;
      // Registers stay writable while down; effect appears after wake
      if (wr_evt && ad == OFS_DRIVE_CTRL) begin
         s_next.drive_output_control = wd;
      end
      if (wr_evt && ad == OFS_RATE_STATUS) begin
         s_next.dsr = wd;
      end
      if (wr_evt && ad == OFS_DISK_RATE) begin
         s_next.rate_config = wd;
      end
      if (rd_evt) begin
         if (ad == OFS_DRIVE_CTRL) begin
            s_next.rdata = s_reg.drive_output_control;
         end else if (ad == OFS_RATE_STATUS) begin
            s_next.rdata = main_status_in;
         end else begin
            s_next.rdata = 8'h00;
         end
      end
      if (s_reg.timer != '0) begin
         s_next.timer = s_reg.timer - CNT_W'(1);
      end
      if ((rd_evt && ad == OFS_RATE_STATUS) || ((rd_evt || wr_evt) && ad == OFS_DATA_FIFO)) begin
         s_next.timer = CNT_W'(PD_COUNT);
      end
      case (s_reg.fsm)
         APW_RESET: begin
            s_next.fsm = APW_AWAKE;
            s_next.timer = CNT_W'(PD_COUNT);
            s_next.cken = 1'b1;
         end
         APW_AWAKE: begin
            s_next.cken = 1'b1;
            if (!power_config_seven[BIT_AUTO_PD]) begin
               s_next.timer = CNT_W'(PD_COUNT);
            end else if (entry_ok && !wake_access && !wake_reset) begin
               s_next.fsm = APW_DOWN;
               s_next.down = 1'b1;
               s_next.cken = 1'b0;
            end
         end
         APW_DOWN: begin
            // Clock to core gated; register file above still serves bus
            s_next.cken = rd_evt | wr_evt;
            if (wake_reset) begin
               s_next.fsm = APW_RESET;
               s_next.down = 1'b0;
               s_next.srst = 1'b1;
            end else if (wake_access || !power_config_seven[BIT_AUTO_PD]) begin
               s_next.fsm = APW_AWAKE;
               s_next.down = 1'b0;
               s_next.cken = 1'b1;
               s_next.timer = CNT_W'(PD_COUNT);
            end
         end
         default: s_next.fsm = APW_RESET;
      endcase
      if (wake_reset && s_reg.fsm != APW_DOWN) begin
         s_next.srst = 1'b1;
      end
      s_next.irq  = s_next.down ? 1'b0 : core_irq_in;
      s_next.dma  = s_next.down ? 1'b0 : core_dma_req_in;
      s_next.drv  = core_drive_in;
      s_next.tri_n = ~s_next.down;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{fsm: APW_RESET, drive_output_control: DOR_RESET_VAL, dsr: DSR_RESET_VAL,
                    rate_config: CCR_RESET_VAL, timer: '0, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign host_rdata        = s_reg.rdata;
   assign irq_out           = s_reg.irq;
   assign dma_request_out   = s_reg.dma;
   assign soft_reset_out    = s_reg.srst;
   assign core_clock_enable = s_reg.cken;
   assign powered_down      = s_reg.down;
   assign drive_out         = s_reg.drv;
   // Enable low while driving
   assign motor_on_oe_n     = {4{~s_reg.tri_n}};
   assign drive_select_oe_n = {4{~s_reg.tri_n}};
   assign write_stream_oe_n = ~s_reg.tri_n;
   assign write_enable_oe_n = ~s_reg.tri_n;

   property p_wake_fifo;
      @(posedge clk) disable iff (!rst_n)
      (s_reg.fsm == APW_DOWN && (rd_evt || wr_evt) && ad == OFS_DATA_FIFO)
         |=> (powered_down == 1'b0 && core_clock_enable);
   endproperty
   a_wake_fifo: assert property (p_wake_fifo) else $error("fifo access did not wake");

   property p_dor_read_stays;
      @(posedge clk) disable iff (!rst_n)
      (s_reg.fsm == APW_DOWN && rd_evt && ad == OFS_DRIVE_CTRL && power_config_seven[7])
         |=> powered_down;
   endproperty
   a_dor_read_stays: assert property (p_dor_read_stays) else $error("control read woke");

   property p_pins_down;
      @(posedge clk) disable iff (!rst_n)
      powered_down |-> (!irq_out && !dma_request_out && motor_on_oe_n == 4'hF);
   endproperty
   a_pins_down: assert property (p_pins_down) else $error("pins active while down");

   property p_timer_restart;
      @(posedge clk) disable iff (!rst_n)
      (s_reg.fsm == APW_DOWN && wake_access) |=> s_reg.timer == CNT_W'(PD_COUNT);
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

   property p_entry;
      @(posedge clk) disable iff (!rst_n)
      $rose(powered_down) |-> $past(s_reg.timer) == '0;
   endproperty
   a_entry: assert property (p_entry) else $error("entered early");

   property p_disable;
      @(posedge clk) disable iff (!rst_n)
      !power_config_seven[7] && !powered_down |=> !powered_down;
   endproperty
   a_disable: assert property (p_disable) else $error("down while disabled");

   property p_reset_wake;
      @(posedge clk) disable iff (!rst_n)
      (s_reg.fsm == APW_DOWN && wake_reset) |=> soft_reset_out ##1 !powered_down;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset wake missed");

   property p_dor_store;
      @(posedge clk) disable iff (!rst_n)
      (wr_evt && ad == OFS_DRIVE_CTRL) |=> s_reg.drive_output_control == $past(wd);
   endproperty
   a_dor_store: assert property (p_dor_store) else $error("write not stored");
endmodule
`default_nettype wire

// file: sim/apw_core_model.sv
// Idle controller core model feeding the wake block
`timescale 1ns/1ps
`default_nettype none
module apw_core_model
   import apw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   output logic [7:0]      main_status,
   output logic            irq,
   output logic            dma_req,
   output logic            head_done,
   output apw_drive_t      drive
);
   logic [11:0] pat_reg;
   // Request toggles so a forced-low output is really seen
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pat_reg <= 12'h000;
      end else begin
         pat_reg <= pat_reg + 12'h001;
      end
   end
   assign main_status = MAIN_STATUS_IDLE;
   assign irq         = 1'b0;
   assign dma_req     = pat_reg[0];
   assign head_done   = 1'b1;
   // Cast needs the full struct width, so pad the pattern to 16 bits
   assign drive       = apw_drive_t'({4'h0, pat_reg} ^ 16'h2AAA);
endmodule
`default_nettype wire

// file: sim/apw_wake_tb_top.sv
// Testbench for the auto powerdown wake block
`timescale 1ns/1ps
`default_nettype none
module apw_wake_tb_top
   import apw_pkg::*;
;
   logic clk, rst_n, rd, wr;
   logic [2:0] addr;
   logic [7:0] wdata, cfg, rdata, ms;
   logic irq_c, dma_c, hd, irq_o, dma_o, srst, cke, pd, wso, weo;
   logic [3:0] mo, dso;
   apw_drive_t drv_c, drv_o, drv_prev;
   int miscompares, compares;
   int srst_cnt;
   // Reset pulse lasts one cycle, shorter than an access task
   always_ff @(posedge clk) begin
      if (srst === 1'b1) begin
         srst_cnt <= srst_cnt + 1;
      end
   end
   apw_core_model apw_core_model_inst (.clk(clk), .rst_n(rst_n), .main_status(ms),
      .irq(irq_c), .dma_req(dma_c), .head_done(hd), .drive(drv_c));
   apw_wake #(.PD_COUNT(50)) apw_wake_inst (.clk(clk), .rst_n(rst_n),
      .host_read_strobe(rd), .host_write_strobe(wr), .host_addr(addr),
      .host_wdata(wdata), .main_status_in(ms), .core_irq_in(irq_c),
      .core_dma_req_in(dma_c), .head_unload_done_in(hd), .power_config_seven(cfg),
      .core_drive_in(drv_c), .host_rdata(rdata), .irq_out(irq_o),
      .dma_request_out(dma_o), .soft_reset_out(srst), .core_clock_enable(cke),
      .powered_down(pd), .drive_out(drv_o), .motor_on_oe_n(mo),
      .drive_select_oe_n(dso), .write_stream_oe_n(wso), .write_enable_oe_n(weo));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobe held 3 cycles, then low long enough for the next access
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      if (w) wr <= 1'b1;
      else rd <= 1'b1;
      repeat (3) @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_pd(input logic exp, input int lim);
      int n;
      n = 0;
      while (pd !== exp && n < lim) begin
         @(posedge clk);
         n++;
      end
      #1;
      if (pd !== exp) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   initial begin
      {rd, wr, addr, wdata} = '0;
      cfg = 8'h80;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      access(1'b1, OFS_DRIVE_CTRL, 8'h04);
      chk(pd, 1'b0);
      wait_pd(1'b1, 120);
      chk({dma_o, irq_o}, 8'h00);
      chk({mo, dso}, 8'hFF);
      chk({wso, weo}, 8'h03);
      chk(cke, 1'b0);
      drv_prev = drv_c;
      @(posedge clk);
      #1;
      chk(drv_o[7:0], drv_prev[7:0]);
      chk(drv_o[15:8], drv_prev[15:8]);
      access(1'b1, OFS_DRIVE_CTRL, 8'h0C);
      access(1'b0, OFS_DRIVE_CTRL, 8'h00);
      chk(rdata, 8'h0C);
      chk(pd, 1'b1);
      access(1'b1, OFS_RATE_STATUS, 8'h02);
      chk(pd, 1'b1);
      access(1'b0, OFS_RATE_STATUS, 8'h00);
      chk(pd, 1'b0);
      chk(rdata, MAIN_STATUS_IDLE);
      repeat (30) @(posedge clk);
      #1;
      chk(pd, 1'b0);
      wait_pd(1'b1, 60);
      access(1'b1, OFS_DATA_FIFO, 8'h5A);
      chk(pd, 1'b0);
      access(1'b0, OFS_DRIVE_CTRL, 8'h00);
      chk(rdata, 8'h0C);
      wait_pd(1'b1, 120);
      access(1'b1, OFS_DRIVE_CTRL, 8'h1C);
      chk(pd, 1'b0);
      chk(mo, 4'h0);
      repeat (80) @(posedge clk);
      #1;
      chk(pd, 1'b0);
      access(1'b1, OFS_DRIVE_CTRL, 8'h0C);
      wait_pd(1'b1, 120);
      access(1'b1, OFS_RATE_STATUS, 8'h80);
      chk(pd, 1'b0);
      chk(8'(srst_cnt), 8'h01);
      wait_pd(1'b1, 120);
      access(1'b0, OFS_DISK_RATE, 8'h00);
      chk(pd, 1'b1);
      cfg <= 8'h00;
      access(1'b0, OFS_DATA_FIFO, 8'h00);
      repeat (150) @(posedge clk);
      #1;
      chk(pd, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
